// [logic/srw_pkg.sv]
/*
 * Constants, types and decode functions of the supervisor reset/watchdog block.
 * Assumes a single 40 MHz clock and a 1 ms enable tick derived from it.
 */
// Contract
// - After power-up reset is held for 50, 200, 400 or 800 ms as the delay field selects.
// - The power-on delay field comes out of reset at code 01, the 200 ms hold.
// - The watchdog period field selects 1.4 s, 200 ms, 25 ms or off for codes 00 to 11.
// - The watchdog period field comes out of reset at code 11, watchdog off.
// - A watchdog expiry at period code 00 or 01 asserts reset for about 200 ms.
// - A watchdog expiry at period code 10 asserts reset for about 25 ms.
// - Each nonvolatile write is a self-timed cycle from its stop, done within 10 ms; a stop arriving while a cycle is busy is ignored and starts none.
// - Manual reset pulses shorter than 50 ns are ignored.
// - Reset follows a manual reset activation no sooner than 500 ns.
// - On power-down the low supply warning comes first and reset about 500 ns later.
// - Reset is asserted within 5 us of the primary supply trip being seen.
// - Pulses shorter than 50 ns on the serial bus inputs are suppressed.
`default_nettype none
package srw_pkg;
  // clock
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // short times in ns, counts in cycles
  localparam int unsigned FILT_NS = 50;
  localparam int unsigned FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DLY_NS = 500;
  localparam int unsigned DLY_CYC = (DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRIP_MAX_NS = 5000;
  localparam int unsigned TRIP_MAX_CYC = TRIP_MAX_NS / CLK_NS;
  // long times in ms, counted in 1 ms ticks
  localparam int unsigned POR_MS_00 = 50;
  localparam int unsigned POR_MS_01 = 200;
  localparam int unsigned POR_MS_10 = 400;
  localparam int unsigned POR_MS_11 = 800;
  localparam int unsigned WD_MS_00 = 1400; // 1.4 s
  localparam int unsigned WD_MS_01 = 200;
  localparam int unsigned WD_MS_10 = 25;
  localparam int unsigned WDR_LONG_MS = 200;
  localparam int unsigned WDR_SHORT_MS = 25;
  localparam int unsigned NV_WC_TYP_MS = 5;
  localparam int unsigned NV_WC_MAX_MS = 10;
  // field codes
  localparam logic [1:0] POR_SEL_DFLT = 2'h1;
  localparam logic [1:0] WD_SEL_SHORT = 2'h2;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_INTS = 12'h008;
  localparam logic [11:0] ADDR_INTM = 12'h00C;

  typedef struct packed {
    logic [1:0] wdog_period_sel; // bits 3:2, hi/lo
    logic [1:0] por_delay_sel;   // bits 1:0, hi/lo
  } srw_ctrl_s;

  typedef struct packed {
    logic nv_done;    // bit 3
    logic low_supply; // bit 2
    logic manual_rst; // bit 1
    logic wdog_tmo;   // bit 0
  } srw_evt_s;

  localparam srw_ctrl_s CTRL_RST = '{wdog_period_sel: WD_SEL_OFF, por_delay_sel: POR_SEL_DFLT};

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_WDRST = 2'b10
  } srw_state_e;

  function automatic logic [11:0] srw_por_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: srw_por_ms = 12'(POR_MS_00);
      2'h1: srw_por_ms = 12'(POR_MS_01);
      2'h2: srw_por_ms = 12'(POR_MS_10);
      2'h3: srw_por_ms = 12'(POR_MS_11);
    endcase
  endfunction : srw_por_ms

  function automatic logic [11:0] srw_wd_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: srw_wd_ms = 12'(WD_MS_00);
      2'h1: srw_wd_ms = 12'(WD_MS_01);
      2'h2: srw_wd_ms = 12'(WD_MS_10);
      2'h3: srw_wd_ms = 12'h000;
    endcase
  endfunction : srw_wd_ms

  function automatic logic [11:0] srw_wdr_ms(input logic [1:0] sel);
    srw_wdr_ms = (sel == WD_SEL_SHORT) ? 12'(WDR_SHORT_MS) : 12'(WDR_LONG_MS);
  endfunction : srw_wdr_ms
endpackage : srw_pkg
`default_nettype wire

// [logic/srw_top.sv]
/*
 * Reset timing and watchdog of a supply supervisor, with an APB register file.
 * Assumes pins are asynchronous to i_ref_clk; i_nv_write_stop is a one-cycle
 * pulse on i_ref_clk from the serial engine at the stop ending a write.
 */
`default_nettype none
module srw_top #(
  parameter int unsigned P_MS_CYC = srw_pkg::MS_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // supervisor pins
  input wire logic i_primary_trip_level,
  input wire logic i_manual_reset_in,
  input wire logic i_wdog_restart,
  // serial bus side
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nv_write_stop,
  // outputs
  output logic o_sys_reset,
  output logic o_low_supply_warning,
  output logic o_nv_write_busy,
  output logic o_scl_filt,
  output logic o_sda_filt,
  output logic o_irq
);

  localparam logic [1:0] FC_MAX = 2'(srw_pkg::FILT_CYC);
  localparam logic [4:0] DLY_MAX = 5'(srw_pkg::DLY_CYC);
  localparam logic [3:0] NV_MS = 4'(srw_pkg::NV_WC_TYP_MS);
  localparam logic [15:0] PRE_MAX = 16'(P_MS_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pin_w;
  logic [4:0] syn1_r;
  logic [4:0] syn2_r;
  assign pin_w = {i_sda, i_scl, i_wdog_restart, i_manual_reset_in, i_primary_trip_level};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      syn1_r <= 5'h00;
      syn2_r <= 5'h00;
    end else begin
      syn1_r <= pin_w;
      syn2_r <= syn1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // glitch filters: manual reset, scl, sda
  logic [2:0] flt_in;
  logic [2:0] flt_w;
  assign flt_in = {syn2_r[4], syn2_r[3], syn2_r[1]};

  for (genvar g = 0; g < 3; g++) begin : g_flt
    logic [1:0] fc_r;
    logic [1:0] fc_nxt;
    logic fv_r;
    logic fv_nxt;
    // flips only after the new level is seen on FC_MAX+1 samples
    always_comb begin
      fc_nxt = 2'h0;
      fv_nxt = fv_r;
      if (flt_in[g] != fv_r) begin
        if (fc_r == FC_MAX) begin
          fv_nxt = flt_in[g];
        end else begin
          fc_nxt = fc_r + 2'h1;
        end
      end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        fc_r <= 2'h0;
        fv_r <= 1'b0;
      end else begin
        fc_r <= fc_nxt;
        fv_r <= fv_nxt;
      end
    end
    assign flt_w[g] = fv_r;
  end

  logic trip;
  logic mr_f;
  assign trip = syn2_r[0];
  assign mr_f = flt_w[0];
  assign o_scl_filt = flt_w[1];
  assign o_sda_filt = flt_w[2];

  //////////////////////////////////////////////////////////////////////////////
  // reset sequencer, watchdog and write-cycle timer
  srw_pkg::srw_ctrl_s ctrl_r;
  srw_pkg::srw_state_e st_r, st_nxt;
  logic [11:0] ms_r, ms_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic [4:0] pend_r, pend_nxt;
  logic [3:0] nv_r, nv_nxt;
  logic nvb_r, nvb_nxt;
  logic rst_r, rst_nxt;
  logic low_r, low_nxt;
  logic rs_d_r, mr_d_r, trip_d_r;
  logic tick, hard_src, hard, rs_evt;
  srw_pkg::srw_evt_s evt;

  assign tick = (pre_r == PRE_MAX);
  assign rs_evt = syn2_r[2] && !rs_d_r;

  always_comb begin
    st_nxt = st_r;
    ms_nxt = tick ? ms_r + 12'h001 : ms_r;
    pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
    pend_nxt = pend_r;
    nv_nxt = nv_r;
    nvb_nxt = nvb_r;
    evt = '0;
    evt.manual_rst = mr_f && !mr_d_r;
    evt.low_supply = trip && !trip_d_r;
    hard_src = trip || mr_f;
    // common 500 ns delay from trip or manual reset to reset
    if (!hard_src) begin
      pend_nxt = 5'h00;
    end else if (pend_r != DLY_MAX) begin
      pend_nxt = pend_r + 5'h01;
    end
    hard = hard_src && (pend_r == DLY_MAX);
    if (hard) begin
      st_nxt = srw_pkg::ST_HOLD;
      ms_nxt = 12'h000;
    end else begin
      unique case (st_r)
        srw_pkg::ST_HOLD: begin
          if (ms_r == srw_pkg::srw_por_ms(ctrl_r.por_delay_sel)) begin
            st_nxt = srw_pkg::ST_RUN;
            ms_nxt = 12'h000;
          end
        end
        srw_pkg::ST_RUN: begin
          if (ctrl_r.wdog_period_sel == srw_pkg::WD_SEL_OFF || rs_evt) begin
            ms_nxt = 12'h000;
          end else if (ms_r == srw_pkg::srw_wd_ms(ctrl_r.wdog_period_sel)) begin
            evt.wdog_tmo = 1'b1;
            st_nxt = srw_pkg::ST_WDRST;
            ms_nxt = 12'h000;
          end
        end
        srw_pkg::ST_WDRST: begin
          if (ms_r == srw_pkg::srw_wdr_ms(ctrl_r.wdog_period_sel)) begin
            st_nxt = srw_pkg::ST_RUN;
            ms_nxt = 12'h000;
          end
        end
        default: begin
          st_nxt = srw_pkg::ST_HOLD;
          ms_nxt = 12'h000;
        end
      endcase
    end
    // realign the ms tick on every state entry
    if (st_nxt != st_r) begin
      pre_nxt = 16'h0000;
    end
    // write cycle; a stop while busy is ignored
    if (nvb_r) begin
      if (tick) begin
        nv_nxt = nv_r + 4'h1;
      end
      if (nv_r == NV_MS) begin
        nvb_nxt = 1'b0;
        nv_nxt = 4'h0;
        evt.nv_done = 1'b1;
      end
    end else if (i_nv_write_stop) begin
      nvb_nxt = 1'b1;
      nv_nxt = 4'h0;
    end
    rst_nxt = (st_nxt != srw_pkg::ST_RUN);
    low_nxt = trip;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= srw_pkg::ST_HOLD;
      ms_r <= 12'h000;
      pre_r <= 16'h0000;
      pend_r <= 5'h00;
      nv_r <= 4'h0;
      nvb_r <= 1'b0;
      rst_r <= 1'b1;
      low_r <= 1'b0;
      rs_d_r <= 1'b0;
      mr_d_r <= 1'b0;
      trip_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ms_r <= ms_nxt;
      pre_r <= pre_nxt;
      pend_r <= pend_nxt;
      nv_r <= nv_nxt;
      nvb_r <= nvb_nxt;
      rst_r <= rst_nxt;
      low_r <= low_nxt;
      rs_d_r <= syn2_r[2];
      mr_d_r <= mr_f;
      trip_d_r <= trip;
    end
  end

  assign o_sys_reset = rst_r;
  assign o_low_supply_warning = low_r;
  assign o_nv_write_busy = nvb_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb registers and interrupt
  srw_pkg::srw_ctrl_s ctrl_nxt;
  logic [3:0] ists_r, ists_nxt;
  logic [3:0] imsk_r, imsk_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic setup, wr, hit;

  always_comb begin
    setup = i_psel && !i_penable;
    wr = i_psel && i_penable && i_pwrite && pready_r;
    hit = 1'b1;
    prdata_nxt = prdata_r;
    unique case (i_paddr)
      srw_pkg::ADDR_CTRL: prdata_nxt = {28'h0000000, ctrl_r};
      srw_pkg::ADDR_STAT: prdata_nxt = {28'h0000000, mr_f, nvb_r, low_r, rst_r};
      srw_pkg::ADDR_INTS: prdata_nxt = {28'h0000000, ists_r};
      srw_pkg::ADDR_INTM: prdata_nxt = {28'h0000000, imsk_r};
      default: begin
        prdata_nxt = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    if (!setup) begin
      prdata_nxt = prdata_r;
    end
    pready_nxt = setup;
    pslverr_nxt = setup && !hit;
    ctrl_nxt = ctrl_r;
    imsk_nxt = imsk_r;
    ists_nxt = ists_r;
    if (wr && i_paddr == srw_pkg::ADDR_CTRL) begin
      ctrl_nxt = i_pwdata[3:0];
    end
    if (wr && i_paddr == srw_pkg::ADDR_INTM) begin
      imsk_nxt = i_pwdata[3:0];
    end
    if (wr && i_paddr == srw_pkg::ADDR_INTS) begin
      ists_nxt = ists_r & ~i_pwdata[3:0];
    end
    // a new event beats a clear in the same cycle
    ists_nxt = ists_nxt | evt;
    irq_nxt = |(ists_nxt & imsk_nxt);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= srw_pkg::CTRL_RST;
      ists_r <= 4'h0;
      imsk_r <= 4'h0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ists_r <= ists_nxt;
      imsk_r <= imsk_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_irq = irq_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int DLY_D = srw_pkg::DLY_CYC;
  localparam int TRIP_D = srw_pkg::TRIP_MAX_CYC - 4;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  por_exit_a: assert property (
    (st_r == srw_pkg::ST_HOLD && st_nxt == srw_pkg::ST_RUN) |->
      ms_r == srw_pkg::srw_por_ms(ctrl_r.por_delay_sel) ##1 !o_sys_reset)
    else $error("power-on hold left at wrong count");
  por_dflt_a: assert property (
    $past(i_rst) |-> ctrl_r.por_delay_sel == srw_pkg::POR_SEL_DFLT)
    else $error("power-on delay default wrong");
  wd_dflt_a: assert property (
    $past(i_rst) |-> ctrl_r.wdog_period_sel == srw_pkg::WD_SEL_OFF)
    else $error("watchdog default not off");
  wd_expire_a: assert property (
    evt.wdog_tmo |-> ctrl_r.wdog_period_sel != srw_pkg::WD_SEL_OFF &&
      ms_r == srw_pkg::srw_wd_ms(ctrl_r.wdog_period_sel) ##1 o_sys_reset)
    else $error("watchdog expiry at wrong count");
  wd_restart_a: assert property (
    (st_r == srw_pkg::ST_RUN && rs_evt && !hard) |=> ms_r == 12'h000 && !evt.wdog_tmo)
    else $error("restart did not clear watchdog count");
  stretch_long_a: assert property (
    (st_r == srw_pkg::ST_WDRST && st_nxt == srw_pkg::ST_RUN &&
      ctrl_r.wdog_period_sel != srw_pkg::WD_SEL_SHORT) |->
      ms_r == 12'(srw_pkg::WDR_LONG_MS))
    else $error("long watchdog reset length wrong");
  stretch_short_a: assert property (
    (st_r == srw_pkg::ST_WDRST && st_nxt == srw_pkg::ST_RUN &&
      ctrl_r.wdog_period_sel == srw_pkg::WD_SEL_SHORT) |->
      ms_r == 12'(srw_pkg::WDR_SHORT_MS))
    else $error("short watchdog reset length wrong");
  nv_cycle_a: assert property (
    (!nvb_r && i_nv_write_stop) |=> nvb_r ##0 (nvb_r throughout (nv_r == 4'h0)[*1]))
    else $error("write cycle did not start");
  nv_end_a: assert property (
    $fell(nvb_r) |-> $past(nv_r) == NV_MS && $past(evt.nv_done))
    else $error("write cycle ended at wrong time");
  mr_glitch_a: assert property (
    $rose(mr_f) |-> $past(syn2_r[1], 1) && $past(syn2_r[1], 2) && $past(syn2_r[1], 3))
    else $error("short manual reset pulse accepted");
  scl_glitch_a: assert property (
    $changed(o_scl_filt) |-> $past(syn2_r[3], 2) == o_scl_filt &&
      $past(syn2_r[3], 3) == o_scl_filt)
    else $error("short scl pulse passed");
  mr_delay_a: assert property (
    $rose(hard) |-> $past(hard_src, DLY_D) && !o_sys_reset ##1 o_sys_reset)
    else $error("manual reset delay wrong");
  low_first_a: assert property (
    $rose(trip) |=> o_low_supply_warning ##0 (pend_r == 5'h01))
    else $error("low warning not first");
  trip_rst_a: assert property (
    $rose(trip) |-> ##[1:TRIP_D] (o_sys_reset || !trip))
    else $error("reset late after supply trip");

  wd_tmo_c: cover property (evt.wdog_tmo ##1 o_sys_reset);
  nv_done_c: cover property (evt.nv_done);
  mr_rst_c: cover property ($rose(hard) && mr_f);
  w1c_race_c: cover property (wr && i_paddr == srw_pkg::ADDR_INTS && |evt);
endmodule : srw_top
`default_nettype wire

// [testbench/srw_host_model.sv]
/*
 * Host partner: stretches watchdog restart kicks and paces write stop pulses.
 * Assumes bench requests arrive as one-cycle pulses on i_ref_clk.
 */
`default_nettype none
module srw_host_model #(
  parameter int unsigned P_MS_CYC = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // bench requests
  input wire logic i_kick,
  input wire logic i_nv_req,
  // pins toward the block
  output logic o_wdog_restart,
  output logic o_nv_write_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned KICK_CYC = 40;
  int unsigned kick_cnt = 0;
  int unsigned gap_cnt = 0;
  logic nv_pend = 1'b0;
  logic stop_r = 1'b0;
  assign o_wdog_restart = (kick_cnt != 0);
  assign o_nv_write_stop = stop_r;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      kick_cnt <= 0;
      gap_cnt <= 10 * P_MS_CYC;
      nv_pend <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      kick_cnt <= i_kick ? KICK_CYC : (kick_cnt != 0) ? kick_cnt - 1 : 0;
      stop_r <= 1'b0;
      // next stop only after a full write cycle
      if (nv_pend && gap_cnt >= 10 * P_MS_CYC) begin
        stop_r <= 1'b1;
        nv_pend <= 1'b0;
        gap_cnt <= 0;
      end else begin
        nv_pend <= nv_pend | i_nv_req;
        if (gap_cnt < 10 * P_MS_CYC) gap_cnt <= gap_cnt + 1;
      end
    end
  end
endmodule : srw_host_model
`default_nettype wire

// [testbench/tb_supervisor_reset_watchdog_timing.sv]
/*
 * Self-checking bench of srw_top with the host partner model.
 * Assumes srw_pkg, srw_top and srw_host_model are compiled first.
 */
`default_nettype none
module tb_supervisor_reset_watchdog_timing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS = 4;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic primary_trip_level = 1'b0, manual_reset_in = 1'b0, scl = 1'b0, sda = 1'b0;
  logic kick = 1'b0, nv_req = 1'b0, restart, stop, pready, pslverr, sys_rst;
  logic low_supply_warning, busy, scl_f, sda_f, irq, err;
  logic [31:0] prdata, rd;
  int miscompares = 0, checks_done = 0, n, n2;

  srw_top #(.P_MS_CYC(MS)) srw_top_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_primary_trip_level(primary_trip_level),
    .i_manual_reset_in(manual_reset_in), .i_wdog_restart(restart), .i_scl(scl), .i_sda(sda),
    .i_nv_write_stop(stop), .o_sys_reset(sys_rst), .o_low_supply_warning(low_supply_warning),
    .o_nv_write_busy(busy), .o_scl_filt(scl_f), .o_sda_filt(sda_f), .o_irq(irq));
  srw_host_model #(.P_MS_CYC(MS)) srw_host_model_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_kick(kick), .i_nv_req(nv_req),
    .o_wdog_restart(restart), .o_nv_write_stop(stop));

  initial begin
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic tmo();
    miscompares++;
    summarize();
  endtask : tmo

  task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      miscompares++;
    end
  endtask : chkv

  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      miscompares++;
    end
  endtask : chkr

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) tmo();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chkv(nm, e, rd);
    chkv("read error", 32'h0, err);
  endtask : rdchk

  // waits for reset (0), warning (1) or busy (2) to reach lvl
  task automatic wait_on(input int s, input logic lvl, input int bound, output int cnt);
    logic cur;
    cnt = 0;
    forever begin
      cur = (s == 0) ? sys_rst : (s == 1) ? low_supply_warning : busy;
      if (cur === lvl) break;
      @(posedge clk);
      cnt++;
      if (cnt > bound) tmo();
    end
  endtask : wait_on

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_por();
    wait_on(0, 1'b0, 4000, n);
    chkr("power-on hold", 200 * MS, 200 * MS + MS + 4, n);
    rdchk("ctrl reset", srw_pkg::ADDR_CTRL, 32'h0000000D);
    rdchk("mask reset", srw_pkg::ADDR_INTM, 32'h00000000);
    apb(1'b1, srw_pkg::ADDR_STAT, 32'h0000000F);
    rdchk("status", srw_pkg::ADDR_STAT, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chkv("unmapped error", 32'h1, err);
    chkv("unmapped data", 32'h0, rd);
  endtask : t_por

  task automatic t_wdog();
    apb(1'b1, srw_pkg::ADDR_INTM, 32'h00000001);
    apb(1'b1, srw_pkg::ADDR_CTRL, 32'h00000009);
    repeat (60) @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    repeat (80) @(posedge clk);
    chkv("reset after restart", 32'h0, sys_rst);
    wait_on(0, 1'b1, 200, n);
    chkr("restart to expiry", 8, 30, n);
    wait_on(0, 1'b0, 400, n);
    chkr("short wdog reset", 50, 150, n);
    chkv("irq set", 32'h1, irq);
    apb(1'b1, srw_pkg::ADDR_INTS, 32'h00000001);
    repeat (2) @(posedge clk);
    chkv("irq cleared", 32'h0, irq);
  endtask : t_wdog

  task automatic t_wdsel();
    int wms;
    for (int s = 0; s < 2; s++) begin
      wms = (s == 0) ? srw_pkg::WD_MS_00 : srw_pkg::WD_MS_01;
      apb(1'b1, srw_pkg::ADDR_CTRL, {28'h0000000, s[1:0], 2'h1});
      wait_on(0, 1'b1, 6000, n);
      chkr("wdog period", (wms - 5) * MS, wms * MS + 8, n);
      wait_on(0, 1'b0, 1400, n);
      chkr("long wdog reset", 400, 1200, n);
    end
    apb(1'b1, srw_pkg::ADDR_CTRL, 32'h0000000D);
    repeat (1000) @(posedge clk);
    chkv("wdog off", 32'h0, sys_rst);
  endtask : t_wdsel

  task automatic t_manual();
    int pms[4] = '{srw_pkg::POR_MS_00, srw_pkg::POR_MS_01, srw_pkg::POR_MS_10,
                   srw_pkg::POR_MS_11};
    manual_reset_in <= 1'b1;
    @(posedge clk);
    manual_reset_in <= 1'b0;
    repeat (60) @(posedge clk);
    chkv("short manual pulse", 32'h0, sys_rst);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, srw_pkg::ADDR_CTRL, {28'h0000000, 2'h3, p[1:0]});
      manual_reset_in <= 1'b1;
      wait_on(0, 1'b1, 200, n);
      chkr("manual reset delay", 20, 32, n);
      manual_reset_in <= 1'b0;
      wait_on(0, 1'b0, 4000, n);
      chkr("power-on hold", pms[p] * MS, pms[p] * MS + MS + 8, n);
    end
  endtask : t_manual

  task automatic t_trip();
    apb(1'b1, srw_pkg::ADDR_INTS, 32'h0000000F);
    primary_trip_level <= 1'b1;
    wait_on(1, 1'b1, 200, n);
    wait_on(0, 1'b1, 200, n2);
    chkr("trip to reset", 1, 200, n + n2);
    chkr("warning lead", 16, 24, n2);
    apb(1'b0, srw_pkg::ADDR_INTS, 32'h00000000);
    chkv("low supply event", 32'h4, rd & 32'h4);
    chkv("irq masked", 32'h0, irq);
    primary_trip_level <= 1'b0;
    wait_on(0, 1'b0, 4000, n);
    chkv("warning released", 32'h0, low_supply_warning);
  endtask : t_trip

  task automatic t_nv();
    nv_req <= 1'b1;
    @(posedge clk);
    nv_req <= 1'b0;
    wait_on(2, 1'b1, 100, n);
    chkr("write start", 0, 4, n);
    wait_on(2, 1'b0, 100, n);
    chkr("write cycle", MS, 10 * MS, n);
    apb(1'b0, srw_pkg::ADDR_INTS, 32'h00000000);
    chkv("write done event", 32'h8, rd & 32'h8);
  endtask : t_nv

  task automatic t_ser();
    scl <= 1'b1;
    sda <= 1'b1;
    @(posedge clk);
    scl <= 1'b0;
    sda <= 1'b0;
    repeat (8) @(posedge clk);
    chkv("scl glitch", 32'h0, scl_f);
    chkv("sda glitch", 32'h0, sda_f);
    scl <= 1'b1;
    sda <= 1'b1;
    repeat (8) @(posedge clk);
    chkv("scl level", 32'h1, scl_f);
    chkv("sda level", 32'h1, sda_f);
  endtask : t_ser

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_wdog();
    t_wdsel();
    t_manual();
    t_trip();
    t_nv();
    t_ser();
    summarize();
  end
endmodule : tb_supervisor_reset_watchdog_timing
`default_nettype wire
